// File: verilog/accr_pkg.sv
// accr_pkg: constants for the channel calibration and configuration register slice.
// assumes a classic wishbone slave with 32-bit data, one word per register.
//
// Functional notes
// - select 00 normal pair, 01 shorted inputs
// - select 10 positive, 11 negative test signal
// - config register at 18h, resets to zero
// - offset upper holds bits 23:8, at 19h
// - offset lower holds 7:0 high, low zero
// - offset word is signed two's complement
// - gain upper holds bits 23:8, at 1Bh
// - gain upper resets to 8000h, unity gain
// - gain lower at 1Ch, holds 7:0 high, low zero
// - gain word unsigned, range zero to two
// - channel two gain lower, low byte zero
`default_nettype none

package accr_pkg;
  // -----------------------------------------------------------------
  // register indices (printed offsets), byte address is four times
  // -----------------------------------------------------------------
  localparam logic [5:0]  IDX_CHAN3_CONFIG       = 6'h18;
  localparam logic [5:0]  IDX_CHAN3_OFFSET_UPPER = 6'h19;
  localparam logic [5:0]  IDX_CHAN3_OFFSET_LOWER = 6'h1a;
  localparam logic [5:0]  IDX_CHAN3_GAIN_UPPER   = 6'h1b;
  localparam logic [5:0]  IDX_CHAN3_GAIN_LOWER   = 6'h1c;
  localparam logic [5:0]  IDX_CHAN2_GAIN_LOWER   = 6'h17; // sits just below 18h

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [15:0] RST_CHAN3_CONFIG       = 16'h0000;
  localparam logic [15:0] RST_CHAN3_OFFSET_UPPER = 16'h0000;
  localparam logic [15:0] RST_CHAN3_OFFSET_LOWER = 16'h0000;
  localparam logic [15:0] RST_CHAN3_GAIN_UPPER   = 16'h8000;
  localparam logic [15:0] RST_CHAN3_GAIN_LOWER   = 16'h0000;
  localparam logic [15:0] RST_CHAN2_GAIN_LOWER   = 16'h0000;

  // -----------------------------------------------------------------
  // field layout and write masks
  // -----------------------------------------------------------------
  localparam logic [15:0] MASK_CONFIG_RW  = 16'hffc7; // 5:3 read-only zero
  localparam logic [15:0] MASK_FULL_RW    = 16'hffff;
  localparam logic [15:0] MASK_LOWER_RW   = 16'hff00; // 7:0 read-only zero
  localparam int          SEL_LSB         = 0;
  localparam int          SEL_MSB         = 1;

  // input select codes
  typedef enum logic [1:0] {
    ACCR_SEL_NORMAL  = 2'h0,
    ACCR_SEL_SHORTED = 2'h1,
    ACCR_SEL_POS_DC  = 2'h2,
    ACCR_SEL_NEG_DC  = 2'h3
  } accr_sel_t;
endpackage : accr_pkg

`default_nettype wire

// File: verilog/accr_reg16.sv
// accr_reg16: one 16-bit register with a per-bit write mask and byte lanes.
// assumes write strobe and data come from logic on the same clock.
`default_nettype none

module accr_reg16 #(
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [15:0] WRITE_MASK  = 16'hffff
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        wr,
  input  wire logic [1:0]  lanes,
  input  wire logic [15:0] wdata,
  output logic      [15:0] value
);
  // -----------------------------------------------------------------
  // merge of written lanes, masked bits stay at zero
  // -----------------------------------------------------------------
  wire logic [15:0] lane_mask = {{8{lanes[1]}}, {8{lanes[0]}}};
  wire logic [15:0] next_value = ((value & ~lane_mask) | (wdata & lane_mask)) & WRITE_MASK;

  // storage, frozen while ce is low
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      value <= RESET_VALUE & WRITE_MASK;
    else if (ce && wr)
      value <= next_value;
  end
endmodule : accr_reg16

`default_nettype wire

// File: verilog/accr_regs.sv
// accr_regs: channel three configuration, offset and gain calibration registers,
// plus the lower gain register of channel two, as a classic wishbone slave.
// assumes a single master on the same clock; the analog mux and calibration math
// sit outside and read the decoded outputs.
//
// Register access over Wishbone was decided locally.
`default_nettype none

module accr_regs (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                ce,
  // wishbone classic slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  output logic                     wb_err_o,
  // channel three front end steering
  output accr_pkg::accr_sel_t      chan3_input_select,
  output logic                     chan3_pos_input_connect,
  output logic                     chan3_neg_input_connect,
  output logic                     chan3_inputs_shorted,
  output logic                     chan3_test_pos,
  output logic                     chan3_test_neg,
  // assembled calibration words
  output logic signed [23:0]       chan3_offset_word,
  output logic        [23:0]       chan3_gain_word,
  output logic        [7:0]        chan2_gain_lo_field
);
  import accr_pkg::*;

  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  wire logic       req        = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire logic [5:0] idx        = wb_adr_i[7:2];
  wire logic       hit_cfg    = (idx == IDX_CHAN3_CONFIG);
  wire logic       hit_ofs_u  = (idx == IDX_CHAN3_OFFSET_UPPER);
  wire logic       hit_ofs_l  = (idx == IDX_CHAN3_OFFSET_LOWER);
  wire logic       hit_gain_u = (idx == IDX_CHAN3_GAIN_UPPER);
  wire logic       hit_gain_l = (idx == IDX_CHAN3_GAIN_LOWER);
  wire logic       hit_g2_l   = (idx == IDX_CHAN2_GAIN_LOWER);
  wire logic       mapped     = hit_cfg | hit_ofs_u | hit_ofs_l | hit_gain_u | hit_gain_l
                                | hit_g2_l;
  wire logic       wr         = req && wb_we_i && mapped;
  wire logic [1:0] lanes      = {wb_sel_i[SEL_MSB], wb_sel_i[SEL_LSB]};
  wire logic [15:0] wdata     = wb_dat_i[15:0];

  // register contents
  wire logic [15:0] cfg_q;
  wire logic [15:0] ofs_u_q;
  wire logic [15:0] ofs_l_q;
  wire logic [15:0] gain_u_q;
  wire logic [15:0] gain_l_q;
  wire logic [15:0] g2_l_q;

  // -----------------------------------------------------------------
  // register instances
  // -----------------------------------------------------------------
  // config: bits 5:3 never store, so they read zero; reserved rw bits are kept
  // as written because the host is expected to write zeros there
  accr_reg16 #(.RESET_VALUE(RST_CHAN3_CONFIG), .WRITE_MASK(MASK_CONFIG_RW)) u_cfg (
    .clk(clk), .resetn(resetn), .ce(ce), .wr(wr && hit_cfg), .lanes(lanes),
    .wdata(wdata), .value(cfg_q)
  );

  accr_reg16 #(.RESET_VALUE(RST_CHAN3_OFFSET_UPPER), .WRITE_MASK(MASK_FULL_RW)) u_ofs_u (
    .clk(clk), .resetn(resetn), .ce(ce), .wr(wr && hit_ofs_u), .lanes(lanes),
    .wdata(wdata), .value(ofs_u_q)
  );

  accr_reg16 #(.RESET_VALUE(RST_CHAN3_OFFSET_LOWER), .WRITE_MASK(MASK_LOWER_RW)) u_ofs_l (
    .clk(clk), .resetn(resetn), .ce(ce), .wr(wr && hit_ofs_l), .lanes(lanes),
    .wdata(wdata), .value(ofs_l_q)
  );

  accr_reg16 #(.RESET_VALUE(RST_CHAN3_GAIN_UPPER), .WRITE_MASK(MASK_FULL_RW)) u_gain_u (
    .clk(clk), .resetn(resetn), .ce(ce), .wr(wr && hit_gain_u), .lanes(lanes),
    .wdata(wdata), .value(gain_u_q)
  );

  accr_reg16 #(.RESET_VALUE(RST_CHAN3_GAIN_LOWER), .WRITE_MASK(MASK_LOWER_RW)) u_gain_l (
    .clk(clk), .resetn(resetn), .ce(ce), .wr(wr && hit_gain_l), .lanes(lanes),
    .wdata(wdata), .value(gain_l_q)
  );

  accr_reg16 #(.RESET_VALUE(RST_CHAN2_GAIN_LOWER), .WRITE_MASK(MASK_LOWER_RW)) u_g2_l (
    .clk(clk), .resetn(resetn), .ce(ce), .wr(wr && hit_g2_l), .lanes(lanes),
    .wdata(wdata), .value(g2_l_q)
  );

  // -----------------------------------------------------------------
  // read mux
  // -----------------------------------------------------------------
  wire logic [15:0] rd_val = hit_cfg    ? cfg_q    :
                             hit_ofs_u  ? ofs_u_q  :
                             hit_ofs_l  ? ofs_l_q  :
                             hit_gain_u ? gain_u_q :
                             hit_gain_l ? gain_l_q :
                             hit_g2_l   ? g2_l_q   : 16'h0000;

  // answer one cycle after the request, then drop the next cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce)
    begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;   // unmapped address answers with err
      if (req && !wb_we_i && mapped)
        wb_dat_o <= {16'h0000, rd_val};
    end
  end

  // -----------------------------------------------------------------
  // input select decode
  // -----------------------------------------------------------------
  wire accr_sel_t sel = accr_sel_t'(cfg_q[1:0]);

  // outputs registered so the analog switches never see a decode glitch
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan3_input_select      <= ACCR_SEL_NORMAL;
      chan3_pos_input_connect <= 1'b1;
      chan3_neg_input_connect <= 1'b1;
      chan3_inputs_shorted    <= 1'b0;
      chan3_test_pos          <= 1'b0;
      chan3_test_neg          <= 1'b0;
    end
    else if (ce)
    begin
      chan3_input_select      <= sel;
      chan3_pos_input_connect <= (sel == ACCR_SEL_NORMAL);
      chan3_neg_input_connect <= (sel == ACCR_SEL_NORMAL);
      chan3_inputs_shorted    <= (sel == ACCR_SEL_SHORTED);
      chan3_test_pos          <= (sel == ACCR_SEL_POS_DC);
      chan3_test_neg          <= (sel == ACCR_SEL_NEG_DC);
    end
  end

  // -----------------------------------------------------------------
  // calibration word assembly
  // -----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan3_offset_word   <= 24'sh000000;
      chan3_gain_word     <= 24'h800000;
      chan2_gain_lo_field <= 8'h00;
    end
    else if (ce)
    begin
      chan3_offset_word   <= signed'({ofs_u_q, ofs_l_q[15:8]});
      chan3_gain_word     <= {gain_u_q, gain_l_q[15:8]};
      chan2_gain_lo_field <= g2_l_q[15:8];
    end
  end
endmodule : accr_regs

`default_nettype wire

// File: verification/accr_regs_monitor.sv
// accr_regs_monitor: port-level checks for the channel calibration register slice.
// assumes one wishbone master that holds each request until ack or err.
`default_nettype none

module accr_regs_monitor (
  input wire logic                clk,
  input wire logic                resetn,
  input wire logic                ce,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [7:0]          wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire logic                wb_err_o,
  input wire accr_pkg::accr_sel_t chan3_input_select,
  input wire logic                chan3_pos_input_connect,
  input wire logic                chan3_inputs_shorted,
  input wire logic                chan3_test_pos,
  input wire logic                chan3_test_neg,
  input wire logic signed [23:0]  chan3_offset_word,
  input wire logic [23:0]         chan3_gain_word
);
  timeunit 1ns;
  timeprecision 1ps;
  import accr_pkg::*;
  // ----------------------------------------------------------------
  // request decode, as the slave should see it
  // ----------------------------------------------------------------
  wire logic       take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && ce; // accepted
  wire logic [5:0] idx  = wb_adr_i[7:2]; // register index, low bits ignored
  wire logic       hit  = idx >= IDX_CHAN2_GAIN_LOWER && idx <= IDX_CHAN3_GAIN_LOWER;
  wire logic       wr   = take && wb_we_i; // write taken this edge
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_ACK_NEXT: assert property (take && hit |=> wb_ack_o && !wb_err_o)
    else $error("mapped request not acknowledged next cycle");
  AST_ERR_NEXT: assert property (take && !hit |=> wb_err_o && !wb_ack_o)
    else $error("unmapped request not refused");
  AST_ACK_PULSE: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack held beyond one cycle");
  AST_RESET_VALUES: assert property ($rose(resetn) |-> chan3_gain_word == 24'h800000
    && chan3_input_select == ACCR_SEL_NORMAL && chan3_offset_word == 24'sh0)
    else $error("wrong values after reset");
  AST_SEL_DECODE: assert property (chan3_pos_input_connect == (chan3_input_select == 2'h0)
    && chan3_inputs_shorted == (chan3_input_select == 2'h1)
    && chan3_test_pos == (chan3_input_select == 2'h2) && chan3_test_neg == (chan3_input_select == 2'h3))
    else $error("steering outputs disagree with select code");
  AST_SEL_WRITE: assert property (wr && idx == IDX_CHAN3_CONFIG && wb_sel_i[0] ##1 ce
    |=> chan3_input_select == $past(wb_dat_i[1:0], 2))
    else $error("select code not taken from write");
  AST_GAIN_UPPER: assert property (wr && idx == IDX_CHAN3_GAIN_UPPER && &wb_sel_i[1:0] ##1 ce
    |=> chan3_gain_word[23:8] == $past(wb_dat_i[15:0], 2))
    else $error("gain upper half misplaced");
  AST_OFFSET_LOWER: assert property (wr && idx == IDX_CHAN3_OFFSET_LOWER && wb_sel_i[1] ##1 ce
    |=> chan3_offset_word[7:0] == $past(wb_dat_i[15:8], 2))
    else $error("offset low byte misplaced");
  AST_LOW_BYTE_ZERO: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] inside {6'h1a, 6'h1c}
    |-> wb_dat_o[7:0] == 8'h00 && wb_dat_o[31:16] == 16'h0000)
    else $error("read-only low byte not zero");

  COV_SEL_WRITE: cover property (wr && idx == IDX_CHAN3_CONFIG);
  COV_REFUSED: cover property (wb_err_o);
  COV_GAIN_READ: cover property (wb_ack_o && !wb_we_i && idx == IDX_CHAN3_GAIN_UPPER);
endmodule : accr_regs_monitor

bind accr_regs accr_regs_monitor i_accr_regs_monitor (.clk, .resetn, .ce, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .chan3_input_select,
  .chan3_pos_input_connect, .chan3_inputs_shorted, .chan3_test_pos, .chan3_test_neg,
  .chan3_offset_word, .chan3_gain_word);
`default_nettype wire

// File: verification/testbench.sv
// testbench: drives the register slice over classic wishbone and checks reads and outputs.
// assumes a one-cycle ack or err after each taken request; ce is held high throughout.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import accr_pkg::*;
  logic               clk = 1'b0, resetn = 1'b0, ce = 1'b1, got_err;
  logic               wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, wb_err_o;
  logic        [7:0]  wb_adr_i = 8'h00, chan2_gain_lo_field;
  logic        [3:0]  wb_sel_i = 4'h0;
  logic        [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        [31:0] rd; // whole word of the last answer, upper half must be zero
  logic               chan3_pos_input_connect, chan3_neg_input_connect, chan3_inputs_shorted;
  logic               chan3_test_pos, chan3_test_neg;
  accr_sel_t          chan3_input_select;
  logic signed [23:0] chan3_offset_word;
  logic        [23:0] chan3_gain_word;
  int                 err_total = 0, samples_checked = 0;

  always #10 clk = ~clk; // 50 mhz
  accr_regs i_accr_regs (.clk, .resetn, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .chan3_input_select,
    .chan3_pos_input_connect, .chan3_neg_input_connect, .chan3_inputs_shorted,
    .chan3_test_pos, .chan3_test_neg, .chan3_offset_word, .chan3_gain_word,
    .chan2_gain_lo_field);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : check

  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // one classic cycle; answer sampled at the rising edge, released at that same edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, w, a, s};
    wb_dat_i <= {16'h0000, d};
    do
    begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
    begin
      err_total++;
      close_out();
    end
    rd = wb_dat_o;
    got_err = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000, 4'h3);
    check(rd, {16'h0000, e});
  endtask : rdchk

  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rdchk(8'h60, 16'h0000);
    rdchk(8'h64, 16'h0000);
    rdchk(8'h68, 16'h0000);
    rdchk(8'h6c, 16'h8000);
    rdchk(8'h70, 16'h0000);
    check(chan3_gain_word, 24'h800000);
    $display("test reset values done");
    // every select code; ones offered only to the read-only bits 5:3
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, 8'h60, 16'h0038 | 16'(c), 4'h3);
      @(negedge clk);
      check({chan3_pos_input_connect, chan3_neg_input_connect, chan3_inputs_shorted,
        chan3_test_pos, chan3_test_neg}, {c == 0, c == 0, c == 1, c == 2, c == 3});
      rdchk(8'h60, 16'(c));
    end
    $display("test select codes done");
    bus(1'b1, 8'h64, 16'hffff, 4'h3);
    bus(1'b1, 8'h68, 16'h80ff, 4'h3);
    bus(1'b1, 8'h64, 16'h1234, 4'h1); // low lane only
    @(negedge clk);
    check({8'h00, chan3_offset_word}, 32'h00ff3480);
    check(chan3_offset_word < 0, 1'b1);
    rdchk(8'h68, 16'h8000);
    rdchk(8'h64, 16'hff34);
    $display("test offset done");
    bus(1'b1, 8'h6c, 16'hffff, 4'h3);
    bus(1'b1, 8'h70, 16'hffff, 4'h3);
    @(negedge clk);
    check(chan3_gain_word, 24'hffffff);
    rdchk(8'h70, 16'hff00);
    rdchk(8'h6c, 16'hffff);
    bus(1'b1, 8'h5c, 16'habcd, 4'h3);
    @(negedge clk);
    check(chan2_gain_lo_field, 8'hab);
    rdchk(8'h5c, 16'hab00);
    $display("test gain done");
    bus(1'b1, 8'h40, 16'h5555, 4'h3);
    check(got_err, 1'b1);
    rdchk(8'h60, 16'h0003);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rdchk(8'h6c, 16'h8000);
    rdchk(8'h60, 16'h0000);
    $display("test refusal and second reset done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
